// ### arcc_defs.vh
// constants for the auto-reclose cycle control block
// assumes a 20 MHz ref_clk and a 32-bit AXI4-Lite register port
`ifndef ARCC_DEFS_VH
`define ARCC_DEFS_VH

// timing: one millisecond tick from the system clock
`define ARCC_CLK_HZ 20000000
`define ARCC_TICK_US 1000
`define ARCC_TICK_CYCLES (`ARCC_CLK_HZ / 1000000 * `ARCC_TICK_US)

// register byte offsets
`define ARCC_OFS_CTRL 8'h00
`define ARCC_OFS_MAX_START 8'h04
`define ARCC_OFS_MAX_HOLD 8'h08
`define ARCC_OFS_DYN_BLOCK 8'h0C
`define ARCC_OFS_SP_DT1 8'h10
`define ARCC_OFS_TP_DT1 8'h20
`define ARCC_OFS_SPECIAL_DT 8'h30
`define ARCC_OFS_STATUS 8'h34

// word indices of the time table (word address minus one), then the plain word addresses of ctrl and status
`define ARCC_TIX_MAX_START 4'h0
`define ARCC_TIX_MAX_HOLD 4'h1
`define ARCC_TIX_DYN_BLOCK 4'h2
`define ARCC_TIX_SP_BASE 4'h3
`define ARCC_TIX_TP_BASE 4'h7
`define ARCC_TIX_SPECIAL 4'hB
`define ARCC_TIX_LAST 4'hB
`define ARCC_WORD_CTRL 6'h00
`define ARCC_WORD_STATUS 6'h0D

// control register fields
`define ARCC_CTRL_ON 0
`define ARCC_CTRL_CYC_LO 1
`define ARCC_CTRL_CYC_HI 3
`define ARCC_CTRL_START_SRC 4
`define ARCC_CTRL_NO_3PH 5
`define ARCC_CTRL_RESET 6'h02
`define ARCC_CYC_MAX 3'h4

// reset values of the time table, milliseconds
`define ARCC_RST_MAX_START 20'h003E8
`define ARCC_RST_MAX_HOLD 20'h00BB8
`define ARCC_RST_DYN_BLOCK 20'h005DC
`define ARCC_RST_SP_DT1 20'h003E8
`define ARCC_RST_SP_DT2 20'h007D0
`define ARCC_RST_SP_DT3 20'h00BB8
`define ARCC_RST_SP_DT4 20'h00FA0
`define ARCC_RST_TP_DT1 20'h001F4
`define ARCC_RST_TP_DT2 20'h00258
`define ARCC_RST_TP_DT3 20'h002BC
`define ARCC_RST_TP_DT4 20'h00320
`define ARCC_RST_SPECIAL_DT 20'h003E8

// AXI responses
`define ARCC_RESP_OKAY 2'h0
`define ARCC_RESP_SLVERR 2'h2

`endif

// ### arcc_timer.v
// millisecond timer with clean restart and elapsed-time compare
// assumes tick is a one-cycle pulse once per millisecond
`timescale 1ns/1ps
`default_nettype none
module arcc_timer
(
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // control
   input wire tick,
   input wire restart,
   input wire run,
   input wire [19:0] limit,
   // result
   output wire expired
);
   reg [19:0] count;

   // elapsed milliseconds, cleared on restart, saturating
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         count <= 20'h00000;
      end
      else if (restart)
      begin
         count <= 20'h00000;
      end
      else if (run && tick && (count != 20'hFFFFF))
      begin
         count <= count + 20'h00001;
      end
   end

   // stale count is hidden in the restart cycle
   // a full limit of ticks must pass, so the time never ends early
   assign expired = !restart && (count > limit);
endmodule // arcc_timer
`default_nettype wire

// ### arcc_top.v
// auto-reclose cycle control: shots, start supervision, dead times
// assumes synchronous inputs from user logic and an AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
`include "arcc_defs.vh"
module arcc_top
#(
   parameter TICK_CYCLES = `ARCC_TICK_CYCLES
)
(
   // clock and reset
   input wire ref_clk,
   input wire rst_n,
   // axi4-lite write
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // protection and breaker logic
   input wire external_block_in,
   input wire general_block_in,
   input wire reclose_start_trip_in,
   input wire breaker_pole_open_in,
   input wire dead_time_hold_in,
   input wire special_first_dead_sel_in,
   input wire reduce_dead_time_in,
   input wire three_phase_trip_in,
   input wire sequence_reset_in,
   // status
   output reg close_request,
   output reg dynamic_blocked,
   output reg reclose_blocked,
   output reg in_progress,
   output reg [1:0] cycle_index
);
   localparam ST_IDLE = 3'h0;
   localparam ST_START = 3'h1;
   localparam ST_HOLD = 3'h2;
   localparam ST_DEAD = 3'h3;
   localparam ST_CLOSE = 3'h4;
   localparam ST_NEXT = 3'h5;
   localparam ST_DYN = 3'h6;
   localparam [14:0] TICK_LAST = TICK_CYCLES[14:0] - 15'h0001;

   reg [5:0] ctrl;
   reg [19:0] time_cfg [0:11];
   reg [2:0] state;
   reg three_latched;
   reg trip_q;
   reg start_restart;
   reg phase_restart;
   reg [14:0] tick_cnt;
   reg tick;
   reg [7:0] aw_addr;
   reg aw_ok;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_ok;
   reg [19:0] dead_limit;
   reg [19:0] phase_limit;
   reg [31:0] rd_mux;
   reg rd_hit;
   wire start_expired;
   wire phase_expired;
   wire [5:0] aw_word;
   wire [5:0] ar_word;
   wire [3:0] aw_tix;
   wire [3:0] ar_tix;
   wire [31:0] ctrl_new;
   wire [31:0] cfg_new;
   wire enabled;
   wire trip_rise;
   wire cycle_three;
   wire [2:0] cyc_sel;
   integer i;

   // reset value of each time table entry
   function [19:0] cfg_default;
      input [3:0] ix;
      begin
         case (ix)
            4'h0: cfg_default = `ARCC_RST_MAX_START;
            4'h1: cfg_default = `ARCC_RST_MAX_HOLD;
            4'h2: cfg_default = `ARCC_RST_DYN_BLOCK;
            4'h3: cfg_default = `ARCC_RST_SP_DT1;
            4'h4: cfg_default = `ARCC_RST_SP_DT2;
            4'h5: cfg_default = `ARCC_RST_SP_DT3;
            4'h6: cfg_default = `ARCC_RST_SP_DT4;
            4'h7: cfg_default = `ARCC_RST_TP_DT1;
            4'h8: cfg_default = `ARCC_RST_TP_DT2;
            4'h9: cfg_default = `ARCC_RST_TP_DT3;
            4'hA: cfg_default = `ARCC_RST_TP_DT4;
            default: cfg_default = `ARCC_RST_SPECIAL_DT;
         endcase
      end
   endfunction

   // byte-lane merge of a write into an old word
   function [31:0] lane_merge;
      input [31:0] old;
      input [31:0] dat;
      input [3:0] strb;
      begin
         lane_merge[7:0] = strb[0] ? dat[7:0] : old[7:0];
         lane_merge[15:8] = strb[1] ? dat[15:8] : old[15:8];
         lane_merge[23:16] = strb[2] ? dat[23:16] : old[23:16];
         lane_merge[31:24] = strb[3] ? dat[31:24] : old[31:24];
      end
   endfunction

   // ****************************************
   // millisecond tick
   // ****************************************

   // one shared tick for every timer
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         tick_cnt <= 15'h0000;
         tick <= 1'b0;
      end
      else if (tick_cnt == TICK_LAST)
      begin
         tick_cnt <= 15'h0000;
         tick <= 1'b1;
      end
      else
      begin
         tick_cnt <= tick_cnt + 15'h0001;
         tick <= 1'b0;
      end
   end

   // ****************************************
   // register port
   // ****************************************

   assign aw_word = aw_addr[7:2];
   assign ar_word = s_axi_araddr[7:2];
   assign aw_tix = aw_word[3:0] - 4'h1;
   assign ar_tix = ar_word[3:0] - 4'h1;
   assign ctrl_new = lane_merge({26'h0000000, ctrl}, w_data, w_strb);
   assign cfg_new = lane_merge({12'h000, time_cfg[aw_tix]}, w_data, w_strb);
   assign s_axi_awready = !aw_ok && !s_axi_bvalid;
   assign s_axi_wready = !w_ok && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   // write channels captured in either order, applied together
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         aw_ok <= 1'b0;
         w_ok <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `ARCC_RESP_OKAY;
         ctrl <= `ARCC_CTRL_RESET;
         for (i = 0; i <= 11; i = i + 1)
            time_cfg[i] <= cfg_default(i[3:0]);
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_addr <= s_axi_awaddr;
            aw_ok <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            w_ok <= 1'b1;
         end
         if (aw_ok && w_ok)
         begin
            aw_ok <= 1'b0;
            w_ok <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `ARCC_RESP_OKAY;
            if (aw_word == `ARCC_WORD_CTRL)
               ctrl <= ctrl_new[5:0];
            else if ((aw_word != 6'h00) && (aw_word <= {2'h0, `ARCC_TIX_LAST} + 6'h01))
               time_cfg[aw_tix] <= cfg_new[19:0];
            else
               s_axi_bresp <= `ARCC_RESP_SLVERR; // status and holes refuse writes
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read decode
   always @*
   begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      if (ar_word == `ARCC_WORD_CTRL)
         rd_mux = {26'h0000000, ctrl};
      else if (ar_word == `ARCC_WORD_STATUS)
         rd_mux = {23'h000000, reclose_blocked, dynamic_blocked, three_latched,
                   cycle_index, 1'b0, state};
      else if ((ar_word != 6'h00) && (ar_word <= {2'h0, `ARCC_TIX_LAST} + 6'h01))
         rd_mux = {12'h000, time_cfg[ar_tix]};
      else
         rd_hit = 1'b0;
   end

   // read answer one cycle after address
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `ARCC_RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_hit ? `ARCC_RESP_OKAY : `ARCC_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // cycle control
   // ****************************************

   assign cyc_sel = ctrl[`ARCC_CTRL_CYC_HI:`ARCC_CTRL_CYC_LO];
   assign enabled = ctrl[`ARCC_CTRL_ON] && (cyc_sel != 3'h0)
                    && !external_block_in && !general_block_in;
   assign trip_rise = reclose_start_trip_in && !trip_q;
   assign cycle_three = three_latched || three_phase_trip_in;

   // dead time by cycle and fault type
   always @*
   begin
      if (three_latched && (cycle_index == 2'h0) && special_first_dead_sel_in)
         dead_limit = time_cfg[`ARCC_TIX_SPECIAL];
      else if (three_latched)
         dead_limit = time_cfg[`ARCC_TIX_TP_BASE + {2'h0, cycle_index}];
      else
         dead_limit = time_cfg[`ARCC_TIX_SP_BASE + {2'h0, cycle_index}];
      case (state)
         ST_HOLD: phase_limit = time_cfg[`ARCC_TIX_MAX_HOLD];
         ST_DYN: phase_limit = time_cfg[`ARCC_TIX_DYN_BLOCK];
         default: phase_limit = dead_limit;
      endcase
   end

   // start-signal timer
   arcc_timer u_start_timer
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick),
      .restart(start_restart),
      .run(state == ST_START),
      .limit(time_cfg[`ARCC_TIX_MAX_START]),
      .expired(start_expired)
   );

   // hold, dead and dynamic block timer
   arcc_timer u_phase_timer
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .tick(tick),
      .restart(phase_restart),
      .run(1'b1),
      .limit(phase_limit),
      .expired(phase_expired)
   );

   // sequence state machine
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         three_latched <= 1'b0;
         cycle_index <= 2'h0;
         trip_q <= 1'b0;
         start_restart <= 1'b0;
         phase_restart <= 1'b0;
         close_request <= 1'b0;
      end
      else
      begin
         trip_q <= reclose_start_trip_in;
         start_restart <= 1'b0;
         phase_restart <= 1'b0;
         close_request <= 1'b0;
         case (state)
            ST_IDLE, ST_NEXT:
            begin
               if (!enabled)
               begin
                  state <= ST_IDLE;
                  three_latched <= 1'b0;
                  cycle_index <= 2'h0;
               end
               else if (trip_rise)
               begin
                  // index has wrapped to zero once all four shots are spent
                  if ((state == ST_NEXT) && ((cycle_index == 2'h0) ||
                      ({1'b0, cycle_index} >= cyc_sel)))
                  begin
                     state <= ST_DYN;
                     phase_restart <= 1'b1;
                  end
                  else if (cycle_three && ctrl[`ARCC_CTRL_NO_3PH])
                  begin
                     state <= ST_DYN;
                     phase_restart <= 1'b1;
                  end
                  else
                  begin
                     state <= ST_START;
                     start_restart <= 1'b1;
                  end
               end
               else if ((state == ST_NEXT) && sequence_reset_in)
               begin
                  state <= ST_IDLE;
                  three_latched <= 1'b0;
                  cycle_index <= 2'h0;
               end
            end
            ST_START:
            begin
               if (!ctrl[`ARCC_CTRL_ON] || general_block_in || external_block_in)
               begin
                  state <= ST_DYN;
                  phase_restart <= 1'b1;
               end
               else if (ctrl[`ARCC_CTRL_START_SRC] ? breaker_pole_open_in
                        : !reclose_start_trip_in)
               begin
                  three_latched <= cycle_three;
                  if (cycle_three && ctrl[`ARCC_CTRL_NO_3PH])
                     state <= ST_DYN;
                  else
                     state <= dead_time_hold_in ? ST_HOLD : ST_DEAD;
                  phase_restart <= 1'b1;
               end
               else if (start_expired)
               begin
                  state <= ST_DYN;
                  phase_restart <= 1'b1;
               end
            end
            ST_HOLD:
            begin
               if (!dead_time_hold_in)
               begin
                  state <= ST_DEAD;
                  phase_restart <= 1'b1;
               end
               else if (phase_expired)
               begin
                  state <= ST_DYN;
                  phase_restart <= 1'b1;
               end
            end
            ST_DEAD:
            begin
               if (!enabled)
               begin
                  state <= ST_DYN;
                  phase_restart <= 1'b1;
               end
               else if (reduce_dead_time_in || phase_expired)
               begin
                  state <= ST_CLOSE;
                  close_request <= 1'b1;
               end
            end
            ST_CLOSE:
            begin
               cycle_index <= cycle_index + 2'h1;
               state <= ST_NEXT;
            end
            ST_DYN:
            begin
               if (phase_expired)
               begin
                  state <= ST_IDLE;
                  three_latched <= 1'b0;
                  cycle_index <= 2'h0;
               end
            end
            default:
            begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // registered status flags
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         dynamic_blocked <= 1'b0;
         reclose_blocked <= 1'b1;
         in_progress <= 1'b0;
      end
      else
      begin
         dynamic_blocked <= (state == ST_DYN);
         reclose_blocked <= !enabled || (state == ST_DYN);
         in_progress <= (state == ST_START) || (state == ST_HOLD) || (state == ST_DEAD);
      end
   end
endmodule // arcc_top
`default_nettype wire

// ### arcc_chk.sv
// checker for the reclose cycle control ports
// assumes binding into arcc_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module arcc_chk
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // block inputs
   input wire logic external_block_in,
   input wire logic general_block_in,
   // status
   input wire logic close_request,
   input wire logic dynamic_blocked,
   input wire logic reclose_blocked,
   input wire logic in_progress,
   input wire logic [1:0] cycle_index
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // ****
   // reclose sequence
   // ****
   a_close_pulse: assert property (close_request |=> !close_request)
      else $error("close longer than one cycle");
   a_close_prog: assert property (close_request |-> $past(in_progress))
      else $error("close without a running cycle");
   a_dyn_quiet: assert property (dynamic_blocked |-> !close_request)
      else $error("close while dynamically blocked");
   a_dyn_entry: assert property ($rose(dynamic_blocked) |-> !in_progress ##[0:1] reclose_blocked)
      else $error("dynamic block without blocked status");
   a_ext_block: assert property (external_block_in |=> reclose_blocked)
      else $error("external block not shown");
   a_gen_block: assert property (general_block_in |=> reclose_blocked)
      else $error("general block not shown");
   a_idle_quiet: assert property (reclose_blocked && !in_progress && !dynamic_blocked |=> !close_request)
      else $error("close while blocked");
   a_index_step: assert property (close_request |=> cycle_index == $past(cycle_index) + 2'h1)
      else $error("index did not advance");
   a_index_only: assert property ($changed(cycle_index) |-> $past(close_request) || cycle_index == 2'h0)
      else $error("index moved without close");
   // ****
   // register bus
   // ****
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read answer dropped");
   a_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   c_close: cover property (close_request);
   c_dyn: cover property ($rose(dynamic_blocked));
   c_third: cover property (cycle_index == 2'h2);
endmodule // arcc_chk
bind arcc_top arcc_chk u_chk
(
   .ref_clk, .rst_n, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .external_block_in, .general_block_in,
   .close_request, .dynamic_blocked, .reclose_blocked, .in_progress, .cycle_index
);
`default_nettype wire

// ### arcc_partner.sv
// protection trip and breaker pole model on the far side
// assumes the bench commands one fault at a time
`timescale 1ns/1ps
`default_nettype none
module arcc_partner
(
   // clock
   input wire logic ref_clk,
   // fault command
   input wire logic go,
   input wire logic tp,
   input wire logic [15:0] trip_len,
   input wire logic [15:0] open_dly,
   // close from the block
   input wire logic close_request,
   // trip and breaker lines
   output var logic reclose_start_trip_in,
   output var logic breaker_pole_open_in,
   output var logic three_phase_trip_in
);
   logic [15:0] cnt = 16'h0000;
   initial
   begin
      reclose_start_trip_in = 1'b0;
      breaker_pole_open_in = 1'b0;
      three_phase_trip_in = 1'b0;
   end
   // trip of set length, pole opens during it, closes on reclose
   always @(posedge ref_clk)
   begin
      cnt <= cnt + 16'h0001;
      if (reclose_start_trip_in && cnt == trip_len) reclose_start_trip_in <= 1'b0;
      if (reclose_start_trip_in && cnt == open_dly) breaker_pole_open_in <= 1'b1;
      if (close_request) breaker_pole_open_in <= 1'b0;
      if (close_request) three_phase_trip_in <= 1'b0;
      if (go)
      begin
         reclose_start_trip_in <= 1'b1;
         breaker_pole_open_in <= 1'b0;
         three_phase_trip_in <= tp;
         cnt <= 16'h0001;
      end
   end
endmodule // arcc_partner
`default_nettype wire

// ### tb_auto_reclose_cycle_control.sv
// bench for the reclose cycle control block
// assumes arcc_top with a 10-cycle tick and the far-side model
`timescale 1ns/1ps
`default_nettype none
module tb_auto_reclose_cycle_control;
   localparam int T = 10;
   logic ref_clk = 1'b0, rst_n = 1'b0, go = 1'b0, tp = 1'b0, smode = 1'b0, seq3 = 1'b0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, rs = 32'hA7F3;
   logic external_block_in = 1'b0, general_block_in = 1'b0, dead_time_hold_in = 1'b0;
   logic special_first_dead_sel_in = 1'b0, reduce_dead_time_in = 1'b0, sequence_reset_in = 1'b0;
   logic [15:0] trip_len = 16'h0001, open_dly = 16'h0000;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp, cycle_index;
   wire [31:0] s_axi_rdata;
   wire reclose_start_trip_in, breaker_pole_open_in, three_phase_trip_in;
   wire close_request, dynamic_blocked, reclose_blocked, in_progress;
   int n_errors = 0, checks_done = 0, cyc = 0, ci = 0;
   logic [19:0] tv [12] = '{20'h14, 20'h14, 20'hF, 20'h3, 20'h4, 20'h5, 20'h6, 20'h7, 20'h8,
      20'h9, 20'hA, 20'hC};
   logic [19:0] rv [12] = '{20'h3E8, 20'hBB8, 20'h5DC, 20'h3E8, 20'h7D0, 20'hBB8, 20'hFA0,
      20'h1F4, 20'h258, 20'h2BC, 20'h320, 20'h3E8};
   arcc_top #(.TICK_CYCLES(T)) dut
   (
      .ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_block_in, .general_block_in,
      .reclose_start_trip_in, .breaker_pole_open_in, .dead_time_hold_in,
      .special_first_dead_sel_in, .reduce_dead_time_in, .three_phase_trip_in,
      .sequence_reset_in, .close_request, .dynamic_blocked, .reclose_blocked, .in_progress,
      .cycle_index
   );
   arcc_partner u_far
   (
      .ref_clk, .go, .tp, .trip_len, .open_dly, .close_request, .reclose_start_trip_in,
      .breaker_pole_open_in, .three_phase_trip_in
   );
   // clock and hang guard
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         n_errors++;
         end_sim();
      end
   end
   // ****
   // helpers
   // ****
   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic int rlen();
      rs = lfsr(rs);
      return 3 + int'(rs[5:0]);
   endfunction
   function automatic int exp_dt(input logic t, input int i, input logic s);
      return t ? ((i == 0 && s) ? tv[11] : tv[7 + i]) : tv[3 + i];
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_win(input int n, input int lo);
      checks_done++;
      if (n < lo || n > lo + T + 10)
      begin
         n_errors++;
         $display("wrong value at %0t: delay %0d from %0d", $time, n, lo);
      end
   endtask
   task automatic end_sim();
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, r);
   endtask
   task automatic axi_rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk(s_axi_rdata, e);
      chk(s_axi_rresp, r);
   endtask
   // one fault; k: 0 close expected, 1 dynamic block, 2 nothing
   task automatic shot(input logic t, input int tl, od, h, rd, k);
      int n;
      int lo;
      @(posedge ref_clk);
      go <= 1'b1;
      tp <= t;
      trip_len <= 16'(tl);
      open_dly <= 16'(od);
      dead_time_hold_in <= (h != 0);
      chk(cycle_index, ci);
      seq3 = seq3 | t;
      lo = (rd != 0) ? rd - 2 : exp_dt(seq3, ci, special_first_dead_sel_in) * T + h - 2;
      @(posedge ref_clk);
      go <= 1'b0;
      @(posedge ref_clk);
      while (!(smode ? breaker_pole_open_in : !reclose_start_trip_in) && !dynamic_blocked)
         @(posedge ref_clk);
      n = 0;
      while (!close_request && !dynamic_blocked && n < 600)
      begin
         @(posedge ref_clk);
         n++;
         if (n == h) dead_time_hold_in <= 1'b0;
         if (n == rd) reduce_dead_time_in <= 1'b1;
      end
      reduce_dead_time_in <= 1'b0;
      dead_time_hold_in <= 1'b0;
      if (k == 0)
      begin
         chk(close_request, 1'b1);
         chk_win(n, lo);
         ci++;
      end
      else if (k == 1)
      begin
         chk(dynamic_blocked, 1'b1);
         n = 0;
         while (dynamic_blocked && n < 1000)
         begin
            @(posedge ref_clk);
            n++;
         end
         ci = 0;
         seq3 = 1'b0;
      end
      else
      begin
         chk({close_request, dynamic_blocked}, 2'h0);
         chk(reclose_blocked, 1'b1);
      end
   endtask
   task automatic seq_rst();
      @(posedge ref_clk);
      sequence_reset_in <= 1'b1;
      @(posedge ref_clk);
      sequence_reset_in <= 1'b0;
      ci = 0;
      seq3 = 1'b0;
   endtask
   // ****
   // main sequence
   // ****
   initial
   begin
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
      axi_rd(8'h00, 32'h2, 2'h0);
      for (int i = 0; i < 12; i++)
         axi_rd(8'(4 * i + 4), {12'h000, rv[i]}, 2'h0);
      axi_rd(8'h34, 32'h100, 2'h0);
      axi_wr(8'h34, 32'hFFFFFFFF, 2'h2);
      axi_rd(8'h38, 32'h0, 2'h2);
      axi_wr(8'h3C, 32'h1, 2'h2);
      for (int i = 0; i < 12; i++)
      begin
         rs = lfsr(rs);
         axi_wr(8'(4 * i + 4), rs, 2'h0);
         axi_rd(8'(4 * i + 4), rs & 32'h000FFFFF, 2'h0);
         axi_wr(8'(4 * i + 4), {12'h000, tv[i]}, 2'h0);
      end
      // off, zero shots, external block, general block
      for (int i = 0; i < 4; i++)
      begin
         axi_wr(8'h00, (i == 0) ? 32'h4 : (i == 1) ? 32'h1 : 32'h5, 2'h0);
         external_block_in <= (i == 2);
         general_block_in <= (i == 3);
         shot(1'b0, 20, 0, 0, 0, 2);
      end
      external_block_in <= 1'b0;
      general_block_in <= 1'b0;
      for (int i = 0; i < 3; i++)
         shot(1'b0, rlen(), 0, 0, 0, i / 2);
      axi_wr(8'h00, 32'h9, 2'h0);
      special_first_dead_sel_in <= 1'b1;
      shot(1'b1, rlen(), 0, 0, 0, 0);
      special_first_dead_sel_in <= 1'b0;
      shot(1'b0, rlen(), 0, 0, 0, 0);
      shot(1'b0, rlen(), 0, 50, 0, 0);
      seq_rst();
      shot(1'b1, rlen(), 0, 0, 0, 0);
      shot(1'b0, rlen(), 0, 0, 20, 0);
      seq_rst();
      shot(1'b0, rlen(), 0, 400, 0, 1);
      shot(1'b0, 300, 0, 0, 0, 1);
      axi_wr(8'h00, 32'h29, 2'h0);
      shot(1'b1, rlen(), 0, 0, 0, 1);
      axi_wr(8'h00, 32'h15, 2'h0);
      smode = 1'b1;
      shot(1'b0, 20, 5, 0, 0, 0);
      shot(1'b0, 60, 0, 0, 0, 1);
      end_sim();
   end
endmodule // tb_auto_reclose_cycle_control
`default_nettype wire
